// ### logic/rct_pkg.sv
// Purpose: Shared constants of the reload/capture timer
// Assumes: Byte address of a register is its index times four
// Notes:   Registers are 8 bits wide, held in bits 7:0 of a word
package rct_pkg;
	// Register indices, byte address = index * 4
	localparam logic [9:0] IDX_CTRL  = 10'h091;
	localparam logic [9:0] IDX_RLL   = 10'h092;
	localparam logic [9:0] IDX_RLH   = 10'h093;
	localparam logic [9:0] IDX_CNTL  = 10'h094;
	localparam logic [9:0] IDX_CNTH  = 10'h095;
	localparam logic [9:0] IDX_CKSEL = 10'h096;
	localparam logic [9:0] IDX_IE    = 10'h097;
	localparam logic [9:0] IDX_ISTAT = 10'h098;
	localparam logic [9:0] IDX_IMASK = 10'h099;

	// Control register fields
	localparam int unsigned CTRL_HF    = 7;
	localparam int unsigned CTRL_LF    = 6;
	localparam int unsigned CTRL_LEN   = 5;
	localparam int unsigned CTRL_CEN   = 4;
	localparam int unsigned CTRL_SPLIT = 3;
	localparam int unsigned CTRL_RUN   = 2;
	localparam int unsigned CTRL_XSEL1 = 1;

	// Clock select register fields
	localparam int unsigned CK_LOW  = 0;
	localparam int unsigned CK_HIGH = 1;

	// Interrupt status and mask fields
	localparam int unsigned ST_HIGH = 0;
	localparam int unsigned ST_LOW  = 1;

	// External clock select codes
	localparam logic [1:0] XCLK_DIV12 = 2'h0;
	localparam logic [1:0] XCLK_CMP   = 2'h1;
	localparam logic [1:0] XCLK_EXT8  = 2'h3;

	// Reset values
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [1:0] CK_RST    = 2'h0;
	localparam logic [1:0] MASK_RST  = 2'h3;

	// Prescaler counts
	localparam int unsigned DIV_SYS = 12;
	localparam int unsigned DIV_EXT = 8;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rct_pkg

// ### logic/rct_tick_gen.sv
// Purpose: Make one-cycle count pulses from slow or foreign sources
// Assumes: ext_osc_in is slower than half of sys_clk
// Notes:   Async inputs pass two flops before any edge logic
`timescale 1ns/1ps
module rct_tick_gen #(
	parameter int unsigned DIV_SYS = rct_pkg::DIV_SYS,
	parameter int unsigned DIV_EXT = rct_pkg::DIV_EXT
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic cmp1_in,
	input  wire logic ext_osc_in,
	rct_tick_if.src   ticks
);
	localparam int unsigned SW = $clog2(DIV_SYS);
	localparam int unsigned EW = $clog2(DIV_EXT);

	logic [1:0]    cmp_sync;
	logic [1:0]    ext_sync;
	logic          cmp_last;
	logic          ext_last;
	logic [SW-1:0] sys_cnt;
	logic [EW-1:0] ext_cnt;
	logic          t_div;
	logic          t_cmp;
	logic          t_ext;
	logic [1:0]    next_cmp_sync;
	logic [1:0]    next_ext_sync;
	logic [SW-1:0] next_sys_cnt;
	logic [EW-1:0] next_ext_cnt;
	logic          next_t_div;
	logic          next_t_cmp;
	logic          next_t_ext;
	logic          ext_rise;

	// Sync stage 0 feeds only stage 1; edges are seen past stage 1
	always_comb begin
		next_cmp_sync = {cmp_sync[0], cmp1_in}; // [R2]
		next_ext_sync = {ext_sync[0], ext_osc_in}; // [R2]
		ext_rise      = ext_sync[1] & ~ext_last;
		next_t_cmp    = cmp_sync[1] & ~cmp_last;
		next_t_div    = (sys_cnt == SW'(DIV_SYS - 1));
		next_sys_cnt  = next_t_div ? '0 : sys_cnt + SW'(1);
		next_t_ext    = ext_rise && (ext_cnt == EW'(DIV_EXT - 1));
		// Wrap on the divide count, so any divider length stays exact
		next_ext_cnt  = !ext_rise ? ext_cnt
			: (next_t_ext ? '0 : ext_cnt + EW'(1)); // [R14]
	end

	// Registered pulses so the core sees clean one-cycle ticks
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_sync <= 2'h0;
			ext_sync <= 2'h0;
			cmp_last <= 1'b0;
			ext_last <= 1'b0;
			sys_cnt  <= '0;
			ext_cnt  <= '0;
			t_div    <= 1'b0;
			t_cmp    <= 1'b0;
			t_ext    <= 1'b0;
		end else begin
			cmp_sync <= next_cmp_sync;
			ext_sync <= next_ext_sync;
			cmp_last <= cmp_sync[1];
			ext_last <= ext_sync[1];
			sys_cnt  <= next_sys_cnt;
			ext_cnt  <= next_ext_cnt;
			t_div    <= next_t_div;
			t_cmp    <= next_t_cmp;
			t_ext    <= next_t_ext;
		end
	end

	assign ticks.tick_div12 = t_div;
	assign ticks.tick_cmp   = t_cmp;
	assign ticks.tick_ext8  = t_ext;
endmodule : rct_tick_gen

// ### logic/rct_tick_if.sv
// Purpose: Count pulses from the prescaler to the timer core
// Assumes: Every pulse lasts one sys_clk cycle
// Notes:   src drives, snk listens
`timescale 1ns/1ps
interface rct_tick_if;
	logic tick_div12;
	logic tick_cmp;
	logic tick_ext8;
	modport src (output tick_div12, output tick_cmp, output tick_ext8);
	modport snk (input tick_div12, input tick_cmp, input tick_ext8);
endinterface : rct_tick_if

// ### logic/rct_timer.sv
// Purpose: 16-bit reload/capture timer with AXI4-Lite registers
// Assumes: Single sys_clk domain, 8-bit registers in bits 7:0
// Notes:   Software writes to counts win over counting that cycle
// How it works
// [R1]: Two count bytes form one 16-bit counter, 16-bit or split mode.
// [R2]: Count clock is sys, sys/12, ext/8 or comparator, synchronised.
// [R3]: 16-bit mode: on 0xFFFF wrap load reload bytes, set high flag.
// [R4]: 16-bit mode: interrupt on every overflow when timer irq enabled.
// [R5]: 16-bit mode: low byte wrap also interrupts when low enable set.
// [R6]: Split mode: each byte reloads from its own reload byte.
// [R7]: Split mode: run bit gates high byte only; low byte always counts.
// [R8]: Clock select 1 picks sys clock, else external code picks source.
// [R9]: Split mode: each byte's wrap sets its own overflow flag.
// [R10]: Split mode: high wrap interrupts; low too if low enable set.
// [R11]: Hardware never clears overflow flags; software writes control.
// [R12]: Software reads both flags to find the interrupt source.
// [R13]: Capture enable selects capture mode; software keeps split at 0.
// [R14]: Capture event on comparator rise or every 8 external cycles.
// [R15]: Capture copies count into reload bytes, sets flag, interrupts.
// [R16]: Software picks a fast count clock and subtracts two captures.
// [R17]: Control register index 0x91, documented layout, resets to 0.
// [R18]: Reserved external code gives no pulses; byte holds its value.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module rct_timer (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        cmp1_in,
	input  wire logic        ext_osc_in,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output      logic        irq
);
	rct_tick_if ticks ();

	rct_tick_gen u_ticks (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.cmp1_in    (cmp1_in),
		.ext_osc_in (ext_osc_in),
		.ticks      (ticks.src)
	);

	// Bus state
	logic        aw_held;
	logic [9:0]  aw_idx;
	logic        w_held;
	logic [7:0]  w_byte;
	logic        w_lane;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        rvalid;
	logic [7:0]  rbyte;
	logic [1:0]  rresp;
	logic        next_aw_held;
	logic [9:0]  next_aw_idx;
	logic        next_w_held;
	logic [7:0]  next_w_byte;
	logic        next_w_lane;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_rvalid;
	logic [7:0]  next_rbyte;
	logic [1:0]  next_rresp;
	logic        wr_go;
	logic        rd_go;
	logic        rd_hit;
	logic        wr_hit;
	logic [9:0]  rd_idx;

	// Timer state
	logic [7:0]  ctrl;
	logic [1:0]  cksel;
	logic        tmr_ie;
	logic [7:0]  rll;
	logic [7:0]  rlh;
	logic [7:0]  cnt_l;
	logic [7:0]  cnt_h;
	logic [1:0]  istat;
	logic [1:0]  imask;
	logic        irq_q;
	logic [7:0]  next_ctrl;
	logic [1:0]  next_cksel;
	logic        next_tmr_ie;
	logic [7:0]  next_rll;
	logic [7:0]  next_rlh;
	logic [7:0]  next_cnt_l;
	logic [7:0]  next_cnt_h;
	logic [1:0]  next_istat;
	logic [1:0]  next_imask;
	logic        next_irq;

	// Datapath terms
	logic        split;
	logic        run;
	logic        cen;
	logic        tk_l;
	logic        tk_h;
	logic        inc_l;
	logic        inc_h;
	logic        ovf_l;
	logic        ovf_h;
	logic        reload16;
	logic        cap_evt;
	logic        set_hf;
	logic        set_lf;

	// Pick one byte's count pulse from its select bit and the code
	function automatic logic pick_tick(input logic sys_sel,
	                                   input logic [1:0] code,
	                                   input logic t_div,
	                                   input logic t_cmp,
	                                   input logic t_ext);
		logic t;
		t = 1'b0;
		if (sys_sel) begin
			t = 1'b1; // [R8]
		end else begin
			case (code)
				rct_pkg::XCLK_DIV12: t = t_div; // [R8]
				rct_pkg::XCLK_CMP:   t = t_cmp; // [R8]
				rct_pkg::XCLK_EXT8:  t = t_ext; // [R8]
				default:             t = 1'b0;  // [R18]
			endcase
		end
		return t;
	endfunction : pick_tick

	// Write and read address decode; one word per index
	assign wr_go  = aw_held & w_held & ~bvalid;
	assign rd_idx = s_axi_araddr[11:2];
	assign rd_go  = s_axi_arvalid & ~rvalid;
	always_comb begin
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		case (aw_idx)
			rct_pkg::IDX_CTRL, rct_pkg::IDX_RLL, rct_pkg::IDX_RLH,
			rct_pkg::IDX_CNTL, rct_pkg::IDX_CNTH, rct_pkg::IDX_CKSEL,
			rct_pkg::IDX_IE, rct_pkg::IDX_ISTAT,
			rct_pkg::IDX_IMASK: wr_hit = 1'b1;
			default:            wr_hit = 1'b0;
		endcase
		next_rbyte = 8'h00;
		case (rd_idx)
			rct_pkg::IDX_CTRL:  next_rbyte = ctrl; // [R17]
			rct_pkg::IDX_RLL:   next_rbyte = rll;
			rct_pkg::IDX_RLH:   next_rbyte = rlh;
			rct_pkg::IDX_CNTL:  next_rbyte = cnt_l;
			rct_pkg::IDX_CNTH:  next_rbyte = cnt_h;
			rct_pkg::IDX_CKSEL: next_rbyte = {6'h00, cksel};
			rct_pkg::IDX_IE:    next_rbyte = {7'h00, tmr_ie};
			rct_pkg::IDX_ISTAT: next_rbyte = {6'h00, istat};
			rct_pkg::IDX_IMASK: next_rbyte = {6'h00, imask};
			default:            next_rbyte = 8'h00;
		endcase
		rd_hit = (next_rbyte != 8'h00) || (rd_idx == rct_pkg::IDX_CTRL)
			|| (rd_idx >= rct_pkg::IDX_RLL && rd_idx <= rct_pkg::IDX_IMASK);
	end

	// Bus channel handshakes; address and data may come in either order
	always_comb begin
		next_aw_held = aw_held;
		next_aw_idx  = aw_idx;
		next_w_held  = w_held;
		next_w_byte  = w_byte;
		next_w_lane  = w_lane;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rresp   = rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_idx  = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_byte = s_axi_wdata[7:0];
			next_w_lane = s_axi_wstrb[0];
		end
		if (wr_go) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_hit ? rct_pkg::RESP_OKAY
				: rct_pkg::RESP_SLVERR;
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rd_go) begin
			next_rvalid = 1'b1;
			next_rresp  = rd_hit ? rct_pkg::RESP_OKAY
				: rct_pkg::RESP_SLVERR;
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// Bus registers; read data is latched when the address is taken
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held <= 1'b0;
			aw_idx  <= 10'h000;
			w_held  <= 1'b0;
			w_byte  <= 8'h00;
			w_lane  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= 2'h0;
			rvalid  <= 1'b0;
			rbyte   <= 8'h00;
			rresp   <= 2'h0;
		end else begin
			aw_held <= next_aw_held;
			aw_idx  <= next_aw_idx;
			w_held  <= next_w_held;
			w_byte  <= next_w_byte;
			w_lane  <= next_w_lane;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rbyte   <= rd_go ? next_rbyte : rbyte;
			rresp   <= next_rresp;
		end
	end

	assign s_axi_awready = ~aw_held & ~bvalid;
	assign s_axi_wready  = ~w_held & ~bvalid;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_arready = ~rvalid;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rresp   = rresp;
	assign s_axi_rdata   = {24'h000000, rbyte};
	assign irq           = irq_q;

	// Mode bits and per-byte count pulses
	always_comb begin
		split = ctrl[rct_pkg::CTRL_SPLIT]; // [R1]
		run   = ctrl[rct_pkg::CTRL_RUN];
		cen   = ctrl[rct_pkg::CTRL_CEN]; // [R13]
		// 16-bit and capture modes count on the low byte's clock
		tk_l = pick_tick(cksel[rct_pkg::CK_LOW], ctrl[1:0],
			ticks.tick_div12, ticks.tick_cmp, ticks.tick_ext8); // [R2]
		tk_h = pick_tick(cksel[rct_pkg::CK_HIGH], ctrl[1:0],
			ticks.tick_div12, ticks.tick_cmp, ticks.tick_ext8); // [R2]
		inc_l = split ? tk_l : (run & tk_l); // [R7]
		ovf_l = inc_l && (cnt_l == 8'hff);
		inc_h = split ? (run & tk_h) : ovf_l; // [R7] [R1]
		ovf_h = inc_h && (cnt_h == 8'hff);
		// Capture mode wraps freely: a reload would corrupt the capture
		reload16 = ~split & ~cen & ovf_h; // [R3]
		// Select bit 1 clear captures on comparator rises, set on osc/8
		cap_evt  = cen & (ctrl[rct_pkg::CTRL_XSEL1] ? ticks.tick_ext8
			: ticks.tick_cmp); // [R14]
		set_hf = cap_evt | (ovf_h & ~cen); // [R3] [R9] [R15]
		set_lf = ovf_l; // [R9]
	end

	// Next state of counts, reloads, control and interrupt state
	always_comb begin
		next_ctrl   = ctrl;
		next_cksel  = cksel;
		next_tmr_ie = tmr_ie;
		next_rll    = rll;
		next_rlh    = rlh;
		next_cnt_l  = cnt_l;
		next_cnt_h  = cnt_h;
		next_istat  = istat;
		next_imask  = imask;
		if (wr_go && w_lane) begin
			case (aw_idx)
				rct_pkg::IDX_CTRL:  next_ctrl   = w_byte; // [R11]
				rct_pkg::IDX_RLL:   next_rll    = w_byte;
				rct_pkg::IDX_RLH:   next_rlh    = w_byte;
				rct_pkg::IDX_CNTL:  next_cnt_l  = w_byte;
				rct_pkg::IDX_CNTH:  next_cnt_h  = w_byte;
				rct_pkg::IDX_CKSEL: next_cksel  = w_byte[1:0];
				rct_pkg::IDX_IE:    next_tmr_ie = w_byte[0];
				rct_pkg::IDX_ISTAT: next_istat  = istat & ~w_byte[1:0];
				rct_pkg::IDX_IMASK: next_imask  = w_byte[1:0];
				default:            next_ctrl   = ctrl;
			endcase
		end
		// Counting yields to a software write to the same count byte
		if (inc_l && !(wr_go && w_lane && aw_idx == rct_pkg::IDX_CNTL)) begin
			if ((split && ovf_l) || reload16)
				next_cnt_l = rll; // [R6] [R3]
			else
				next_cnt_l = cnt_l + 8'h01;
		end
		if (inc_h && !(wr_go && w_lane && aw_idx == rct_pkg::IDX_CNTH)) begin
			if ((split && ovf_h) || reload16)
				next_cnt_h = rlh; // [R6] [R3]
			else
				next_cnt_h = cnt_h + 8'h01;
		end
		// Capture beats a software write to the reload bytes
		if (cap_evt) begin
			next_rll = cnt_l; // [R15]
			next_rlh = cnt_h; // [R15]
		end
		// Hardware only sets flags, and a set beats a clearing write
		next_ctrl[rct_pkg::CTRL_HF] = next_ctrl[rct_pkg::CTRL_HF] | set_hf;
		next_ctrl[rct_pkg::CTRL_LF] = next_ctrl[rct_pkg::CTRL_LF] | set_lf;
		// Interrupt events: high always, low only with its enable
		next_istat[rct_pkg::ST_HIGH] = next_istat[rct_pkg::ST_HIGH]
			| set_hf; // [R4] [R10] [R15]
		next_istat[rct_pkg::ST_LOW] = next_istat[rct_pkg::ST_LOW]
			| (set_lf & ctrl[rct_pkg::CTRL_LEN]); // [R5] [R10]
		next_irq = tmr_ie & |(istat & imask); // [R4] [R5] [R10]
	end

	// Timer registers, all cleared by reset except imask, which resets to 3
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl   <= rct_pkg::CTRL_RST; // [R17]
			cksel  <= rct_pkg::CK_RST;
			tmr_ie <= 1'b0;
			rll    <= rct_pkg::BYTE_RST;
			rlh    <= rct_pkg::BYTE_RST;
			cnt_l  <= rct_pkg::BYTE_RST;
			cnt_h  <= rct_pkg::BYTE_RST;
			istat  <= 2'h0;
			imask  <= rct_pkg::MASK_RST;
			irq_q  <= 1'b0;
		end else begin
			ctrl   <= next_ctrl;
			cksel  <= next_cksel;
			tmr_ie <= next_tmr_ie;
			rll    <= next_rll;
			rlh    <= next_rlh;
			cnt_l  <= next_cnt_l;
			cnt_h  <= next_cnt_h;
			istat  <= next_istat;
			imask  <= next_imask;
			irq_q  <= next_irq;
		end
	end
endmodule : rct_timer

// ### verif/rct_timer_sva.sv
// Purpose: Bus and interrupt checks at the timer's ports
// Assumes: One sys_clk domain, answer timing as handed over
// Notes:   Attached to every timer instance by the bind below
`timescale 1ns/1ps
module rct_timer_sva (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// Both write halves taken at one edge
	sequence wr_take_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take_s;
		s_axi_arvalid && s_axi_arready;
	endsequence

	// Answers come in a fixed short time and release after handshake
	wr_answer_a: assert property (wr_take_s |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered in time");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready) else $error("write answer stuck");
	rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
		else $error("read not answered in time");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready) else $error("read answer stuck");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	wr_block_a: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write taken early");
	// Registers are one byte wide, only two answer codes exist
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] ==
		24'h0 && s_axi_rresp != 2'h1 && s_axi_rresp != 2'h3)
		else $error("bad read word");
	irq_rst_a: assert property ($fell(sys_rst) |-> !irq)
		else $error("interrupt high after reset");
	// Hardware never clears events, so only a bus write drops irq
	irq_hold_a: assert property ($fell(irq) |-> $past(s_axi_bvalid))
		else $error("interrupt dropped without a write");
endmodule : rct_timer_sva

bind rct_timer rct_timer_sva u_sva (.sys_clk, .sys_rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the reload/capture timer
// Assumes: Register timing as handed over by the designer
// Notes:   Reads race the running counter, so some checks use windows
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk = 1'b0, sys_rst = 1'b1;
	logic        cmp1_in = 1'b0, ext_osc_in = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, irq;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [7:0]  v;
	logic [15:0] c1, c2;
	int          n_errors = 0, checks_done = 0, cyc = 0, t1;

	rct_timer uut (.sys_clk, .sys_rst, .cmp1_in, .ext_osc_in,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .irq);

	// 125 MHz clock and a cycle count for timed stimulus
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : idle

	task automatic chk(input string nm, input logic [15:0] ex,
		input logic [15:0] got);
		checks_done++;
		if (got !== ex) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	// Write: address and data together, bready held until the answer
	task automatic wr(input logic [9:0] ix, input logic [7:0] d,
		input logic [1:0] er = rct_pkg::RESP_OKAY);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= {ix, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge sys_clk);
			if (!a && s_axi_awready) begin
				a = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge sys_clk);
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", {14'h0, er}, {14'h0, s_axi_bresp});
		// One idle edge, so a following call never re-raises bready at once
		@(posedge sys_clk);
	endtask : wr

	// Read: rready held from the request until the answer
	task automatic rd(input logic [9:0] ix, output logic [7:0] d,
		output logic [1:0] r);
		s_axi_araddr <= {ix, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge sys_clk);
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
		// One idle edge, so a following call never re-raises rready at once
		@(posedge sys_clk);
	endtask : rd

	task automatic rc(input logic [9:0] ix, input logic [7:0] ex,
		input string nm);
		logic [7:0] d;
		logic [1:0] r;
		rd(ix, d, r);
		chk(nm, {6'h0, rct_pkg::RESP_OKAY, ex}, {6'h0, r, d});
	endtask : rc

	// Pulses on the comparator or the oscillator, h cycles per phase
	task automatic toggle(input logic ext, input int n, input int h);
		repeat (n) begin
			if (ext)
				ext_osc_in <= 1'b1;
			else
				cmp1_in <= 1'b1;
			idle(h);
			ext_osc_in <= 1'b0;
			cmp1_in <= 1'b0;
			idle(h);
		end
	endtask : toggle

	task automatic give_verdict();
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	initial begin : main
		idle(8);
		sys_rst <= 1'b0;
		idle(1);
		rc(rct_pkg::IDX_CTRL, 8'h00, "ctrl reset");
		rc(rct_pkg::IDX_IMASK, 8'h03, "imask reset");
		wr(10'h0a0, 8'h5a, rct_pkg::RESP_SLVERR);
		rd(10'h0a0, v, rs);
		chk("unmapped", 16'h0200, {6'h0, rs, v});
		// 16-bit wrap from 0xfff0 reloads 0x1200 and raises both flags
		wr(rct_pkg::IDX_IE, 8'h01);
		wr(rct_pkg::IDX_CKSEL, 8'h01);
		wr(rct_pkg::IDX_RLH, 8'h12);
		wr(rct_pkg::IDX_CNTL, 8'hf0);
		wr(rct_pkg::IDX_CNTH, 8'hff);
		wr(rct_pkg::IDX_CTRL, 8'h24);
		idle(30);
		rc(rct_pkg::IDX_CTRL, 8'he4, "flags 16");
		rc(rct_pkg::IDX_CNTH, 8'h12, "reloaded");
		rc(rct_pkg::IDX_ISTAT, 8'h03, "events 16");
		chk("irq 16", 16'h1, {15'h0, irq});
		idle(100);
		rc(rct_pkg::IDX_CTRL, 8'he4, "flags kept");
		wr(rct_pkg::IDX_IMASK, 8'h00);
		idle(2);
		chk("irq masked", 16'h0, {15'h0, irq});
		wr(rct_pkg::IDX_IMASK, 8'h03);
		wr(rct_pkg::IDX_CTRL, 8'h00);
		wr(rct_pkg::IDX_ISTAT, 8'h03);
		idle(2);
		chk("irq cleared", 16'h0, {15'h0, irq});
		rc(rct_pkg::IDX_CTRL, 8'h00, "flags cleared");
		// Split: low byte runs alone until run is set
		wr(rct_pkg::IDX_CKSEL, 8'h03);
		wr(rct_pkg::IDX_RLL, 8'hf0);
		wr(rct_pkg::IDX_RLH, 8'h40);
		wr(rct_pkg::IDX_CNTH, 8'h55);
		wr(rct_pkg::IDX_CNTL, 8'hf0);
		wr(rct_pkg::IDX_CTRL, 8'h08);
		idle(40);
		rc(rct_pkg::IDX_CNTH, 8'h55, "high held");
		rc(rct_pkg::IDX_CTRL, 8'h48, "low flag");
		rc(rct_pkg::IDX_ISTAT, 8'h00, "no event");
		rd(rct_pkg::IDX_CNTL, v, rs);
		chk("low reload", 16'h000f, {12'h0, v[7:4]});
		wr(rct_pkg::IDX_CNTH, 8'hfe);
		wr(rct_pkg::IDX_CTRL, 8'h0c);
		idle(20);
		rc(rct_pkg::IDX_CTRL, 8'hcc, "split flags");
		rd(rct_pkg::IDX_CNTH, v, rs);
		chk("high reload", 16'h0001, {14'h0, v[7:6]});
		chk("irq split", 16'h1, {15'h0, irq});
		wr(rct_pkg::IDX_CTRL, 8'h06);
		wr(rct_pkg::IDX_ISTAT, 8'h03);
		// Reserved source, then sys/12, comparator and oscillator/8
		wr(rct_pkg::IDX_CKSEL, 8'h00);
		wr(rct_pkg::IDX_CNTL, 8'h33);
		idle(50);
		rc(rct_pkg::IDX_CNTL, 8'h33, "reserved");
		wr(rct_pkg::IDX_CTRL, 8'h04);
		wr(rct_pkg::IDX_CNTL, 8'h00);
		idle(120);
		rd(rct_pkg::IDX_CNTL, v, rs);
		chk("div12", 16'h1, {15'h0, v >= 8'h09 && v <= 8'h0b});
		wr(rct_pkg::IDX_CTRL, 8'h05);
		wr(rct_pkg::IDX_CNTL, 8'h00);
		toggle(1'b0, 5, 6);
		idle(8);
		rc(rct_pkg::IDX_CNTL, 8'h05, "cmp count");
		wr(rct_pkg::IDX_CTRL, 8'h07);
		wr(rct_pkg::IDX_CNTL, 8'h00);
		toggle(1'b1, 16, 4);
		idle(8);
		rc(rct_pkg::IDX_CNTL, 8'h02, "ext count");
		// Capture two comparator rises exactly 300 cycles apart
		wr(rct_pkg::IDX_CKSEL, 8'h01);
		wr(rct_pkg::IDX_CTRL, 8'h14);
		wr(rct_pkg::IDX_ISTAT, 8'h03);
		t1 = cyc;
		toggle(1'b0, 1, 6);
		rd(rct_pkg::IDX_CTRL, v, rs);
		chk("capture flag", 16'h1, {15'h0, v[7]});
		rd(rct_pkg::IDX_RLL, c1[7:0], rs);
		rd(rct_pkg::IDX_RLH, c1[15:8], rs);
		chk("capture irq", 16'h1, {15'h0, irq});
		while (cyc < t1 + 300)
			idle(1);
		toggle(1'b0, 1, 6);
		rd(rct_pkg::IDX_RLL, c2[7:0], rs);
		rd(rct_pkg::IDX_RLH, c2[15:8], rs);
		chk("capture span", 16'h012c, c2 - c1);
		// Oscillator capture: only the eighth rise raises the high flag
		wr(rct_pkg::IDX_CTRL, 8'h16);
		toggle(1'b1, 7, 4);
		idle(8);
		rd(rct_pkg::IDX_CTRL, v, rs);
		chk("no capture yet", 16'h0, {15'h0, v[7]});
		toggle(1'b1, 1, 4);
		idle(8);
		rd(rct_pkg::IDX_CTRL, v, rs);
		chk("ext capture", 16'h1, {15'h0, v[7]});
		give_verdict();
	end

	// Cut a hang short well beyond the expected run length
	initial begin : watchdog
		idle(20000);
		n_errors++;
		give_verdict();
	end
endmodule : tb_top
